// [common/dbs_defines.vh]
// Offsets, field positions, codes and reset values of the device and bus status registers
// Behaviour
// - Bit 9 of device status shows frame checking enabled, read-only.
// - Device status reads are answered regardless of the frame-check field.
// - Frame-check failure sets bit 8; bit clears on read.
// - The fixed check on/off sequence never sets the frame-check error bit.
// - Bits 7:6 hold prior state: 00 cleared, 01 failure, 10 sleep.
// - Watchdog, overtemp, regulator undervoltage, unwakeable sleep load failure code.
// - Wake from fail-safe also loads the failure code.
// - Regular sleep or sleep with wake flags set loads sleep code.
// - Bit 4 shows software development mode from hardware.
// - Bits 3:2 count watchdog failures, saturating at 11.
// - Watchdog count is updated and cleared by the device, not reads.
// - Invalid serial command sets bit 1.
// - Bit 1 clears only through a serial command.
// - Reset gives zero device status; restart keeps bits 9:6 and 4:0.
// - Device status bits 15:10 and 5 read zero.
// - Bus status 6:5 LIN fault: 01 thermal, 10 txd, 11 bus; clear on read.
// - CAN timeout sets bus status bit 4; clears on read.
// - Bit 3 set when a system error blocks selective wake.
// - Bus status 2:1 CAN fault: 01 thermal, 10 txd, 11 bus; clear on read.
// - CAN supply undervoltage sets bit 0 and disables the CAN transmitter.
// - Supply undervoltage detection only in CAN normal or receive-only mode.
// - Reset gives zero bus status; restart keeps bits 6:0, upper zero.
// - Timeout sets only with selective wake enabled; stays after silence ends.
// - Timeout clear is blocked until next falling edge of interrupt output.
`ifndef DBS_DEFINES_VH
`define DBS_DEFINES_VH
`define DBS_DEVICE_INFO_STATUS_ADDR   7'h42
`define DBS_BUS_STAT_ADDR   7'h43
`define DBS_REG_RESET       16'h0000
`define DBS_DEV_CRC_EN_BIT  9
`define DBS_DEV_CRC_ERR_BIT 8
`define DBS_DEV_PRIOR_HI    7
`define DBS_DEV_PRIOR_LO    6
`define DBS_DEV_SWDEV_BIT   4
`define DBS_DEV_WDCNT_HI    3
`define DBS_DEV_WDCNT_LO    2
`define DBS_DEV_BADCMD_BIT  1
`define DBS_DEV_FAIL_BIT    0
`define DBS_BUS_LIN_HI      6
`define DBS_BUS_LIN_LO      5
`define DBS_BUS_CAN_TIMEOUT_FLAG_BIT   4
`define DBS_BUS_SELECTIVE_WAKE_SYSTEM_ERROR_BIT  3
`define DBS_BUS_CAN_HI      2
`define DBS_BUS_CAN_LO      1
`define DBS_BUS_CANUV_BIT   0
`define DBS_PRIOR_CLEARED   2'h0
`define DBS_PRIOR_FAILURE   2'h1
`define DBS_PRIOR_SLEEP     2'h2
`define DBS_WDCNT_MAX       2'h3
`endif

// [hdl/dbs_code_latch.v]
// Clear-on-read two-bit fault code holder
`timescale 1ns/1ps
module dbs_code_latch (
  // Clock and reset
  input  wire       i_clk_sys,
  input  wire       i_nrst,
  // Control
  input  wire       i_wipe,
  input  wire       i_set,
  input  wire [1:0] i_code,
  input  wire       i_clr,
  // State
  output reg  [1:0] o_code
);

  // Set wins over clear; newest nonzero code replaces older one
  always @(posedge i_clk_sys) begin
    if (!i_nrst || i_wipe) begin
      o_code <= 2'h0;
    end else if (i_set && (i_code != 2'h0)) begin
      o_code <= i_code;
    end else if (i_clr) begin
      o_code <= 2'h0;
    end
  end

endmodule // dbs_code_latch

// [hdl/dbs_status_regs.v]
// Device information and bus communication status registers
`timescale 1ns/1ps
`include "dbs_defines.vh"
module dbs_status_regs (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_nrst,
  input  wire        i_soft_reset,
  input  wire        i_restart,
  // Serial access from the frame decoder
  input  wire        i_rd_stb,
  input  wire [6:0]  i_rd_addr,
  input  wire        i_rd_clear,
  input  wire        i_crc_seq,
  input  wire        i_crc_bad,
  input  wire        i_cmd_invalid,
  input  wire        i_crc_enabled,
  // Device events
  input  wire        i_watchdog_fault_count,
  input  wire        i_wd_clear,
  input  wire        i_severe_overtemp_shutdown,
  input  wire        i_main_regulator_undervoltage,
  input  wire        i_sleep_no_wake_src,
  input  wire        i_failsafe_wake,
  input  wire        i_sleep_entry,
  input  wire        i_failure,
  input  wire        i_software_development_mode_flag_pin,
  // Transceiver events
  input  wire        i_lin_fault_set,
  input  wire [1:0]  i_lin_fault_code,
  input  wire        i_can_fault_set,
  input  wire [1:0]  i_can_fault_code,
  input  wire        i_can_bus_silence_flag,
  input  wire        i_selective_wake_enable_bit,
  input  wire        i_swk_sys_error,
  input  wire        i_can_supply_low,
  input  wire        i_can_normal_mode,
  input  wire        i_can_rx_only_mode,
  input  wire        i_interrupt_out_n,
  // Read answer and side effects
  output reg         o_rd_valid,
  output reg  [15:0] o_rd_data,
  output reg         o_can_tx_disable
);

  // Pin synchronisers; only the second stage is read
  reg  [1:0] swdev_sync_q;
  reg  [1:0] interrupt_out_n_sync_q;
  reg        interrupt_out_n_prev_q;
  // Software development mode as seen after two stages
  wire       software_development_mode_flag_s = swdev_sync_q[1];
  // Falling edge of the synchronised interrupt pin
  wire       interrupt_out_n_fall = interrupt_out_n_prev_q & ~interrupt_out_n_sync_q[1];

  // Device status fields
  reg        crc_err_q;
  reg  [1:0] prior_q;
  reg  [1:0] wd_cnt_q;
  reg        bad_cmd_q;
  reg        fail_q;
  // Bus status fields and timeout clear hold-off
  reg        can_timeout_flag_q;
  reg        can_timeout_flag_arm_q;
  reg        can_timeout_flag_hold_q;
  reg        selective_wake_system_error_q;
  reg        can_low_q;
  wire [1:0] lin_code;
  wire [1:0] can_code;

  // Strobed read aimed at one register address
  function hit_at;
    input       stb;
    input [6:0] addr;
    input [6:0] target;
    begin
      hit_at = stb & (addr == target);
    end
  endfunction

  // Decoded reads; the frame-check field takes no part in them
  wire rd_dev = hit_at(i_rd_stb, i_rd_addr, `DBS_DEVICE_INFO_STATUS_ADDR);
  wire rd_bus = hit_at(i_rd_stb, i_rd_addr, `DBS_BUS_STAT_ADDR);
  // Clear strobes; a read without clear leaves every flag alone
  wire clr_dev = rd_dev & i_rd_clear;
  wire clr_bus = rd_bus & i_rd_clear;
  // Power-on or soft reset wipes; restart is left unused on purpose,
  // since a restart keeps every field that is not reserved
  wire wipe = (!i_nrst) | i_soft_reset;
  // Causes that load the restart-after-failure code
  wire fail_src = i_watchdog_fault_count | i_severe_overtemp_shutdown | i_main_regulator_undervoltage
                | i_sleep_no_wake_src | i_failsafe_wake;
  // Supply comparator enable by transceiver mode
  wire uv_det_en = i_can_normal_mode | i_can_rx_only_mode;

  // Compose device status image; reserved bits 15:10 and 5
  // keep the zero of the reset image
  function [15:0] dev_image;
    input       crc_en;
    input       crc_err;
    input [1:0] prior;
    input       swdev;
    input [1:0] wdc;
    input       bad;
    input       fl;
    begin
      dev_image = `DBS_REG_RESET;
      dev_image[`DBS_DEV_CRC_EN_BIT] = crc_en;
      dev_image[`DBS_DEV_CRC_ERR_BIT] = crc_err;
      dev_image[`DBS_DEV_PRIOR_HI:`DBS_DEV_PRIOR_LO] = prior;
      dev_image[`DBS_DEV_SWDEV_BIT] = swdev;
      dev_image[`DBS_DEV_WDCNT_HI:`DBS_DEV_WDCNT_LO] = wdc;
      dev_image[`DBS_DEV_BADCMD_BIT] = bad;
      dev_image[`DBS_DEV_FAIL_BIT] = fl;
    end
  endfunction

  // Compose bus status image; bits 15:7 stay zero
  function [15:0] bus_image;
    input [1:0] lin;
    input       can_timeout_flag;
    input       selective_wake_system_error;
    input [1:0] can;
    input       canuv;
    begin
      bus_image = `DBS_REG_RESET;
      bus_image[`DBS_BUS_LIN_HI:`DBS_BUS_LIN_LO] = lin;
      bus_image[`DBS_BUS_CAN_TIMEOUT_FLAG_BIT] = can_timeout_flag;
      bus_image[`DBS_BUS_SELECTIVE_WAKE_SYSTEM_ERROR_BIT] = selective_wake_system_error;
      bus_image[`DBS_BUS_CAN_HI:`DBS_BUS_CAN_LO] = can;
      bus_image[`DBS_BUS_CANUV_BIT] = canuv;
    end
  endfunction

  // Synchronise asynchronous pins; the interrupt stages reset high,
  // its idle level, so no false falling edge follows reset
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      swdev_sync_q <= 2'h0;
      interrupt_out_n_sync_q  <= 2'h3;
      interrupt_out_n_prev_q  <= 1'b1;
    end else begin
      swdev_sync_q <= {swdev_sync_q[0], i_software_development_mode_flag_pin};
      interrupt_out_n_sync_q  <= {interrupt_out_n_sync_q[0], i_interrupt_out_n};
      interrupt_out_n_prev_q  <= interrupt_out_n_sync_q[1];
    end
  end

  // Device status flags; restart keeps contents, only reset wipes
  always @(posedge i_clk_sys) begin
    if (wipe) begin
      crc_err_q <= 1'b0;
      prior_q   <= `DBS_PRIOR_CLEARED;
      bad_cmd_q <= 1'b0;
      fail_q    <= 1'b0;
    end else begin
      // Frame-check error; the fixed on/off sequence is exempt
      if (i_crc_bad && !i_crc_seq) begin
        crc_err_q <= 1'b1;
      end else if (clr_dev) begin
        crc_err_q <= 1'b0;
      end

      // Prior state; a failure outranks a sleep entry that lands
      // in the same cycle
      if (fail_src) begin
        prior_q <= `DBS_PRIOR_FAILURE;
      end else if (i_sleep_entry) begin
        prior_q <= `DBS_PRIOR_SLEEP;
      end else if (clr_dev) begin
        prior_q <= `DBS_PRIOR_CLEARED;
      end

      // Bad command flag; the serial read with clear is its only clear
      if (i_cmd_invalid) begin
        bad_cmd_q <= 1'b1;
      end else if (clr_dev) begin
        bad_cmd_q <= 1'b0;
      end

      // General failure flag, clear on read
      if (i_failure) begin
        fail_q <= 1'b1;
      end else if (clr_dev) begin
        fail_q <= 1'b0;
      end
    end
  end

  // Watchdog failure count; saturates at three or more, and only
  // the device clears it, never a serial read
  always @(posedge i_clk_sys) begin
    if (wipe) begin
      wd_cnt_q <= 2'h0;
    end else if (i_watchdog_fault_count && (wd_cnt_q != `DBS_WDCNT_MAX)) begin
      wd_cnt_q <= wd_cnt_q + 2'h1;
    end else if (i_wd_clear && !i_watchdog_fault_count) begin
      wd_cnt_q <= 2'h0;
    end
  end

  // LIN and CAN fault code holders; reset is applied inside them,
  // so only the soft reset is passed in as the wipe
  dbs_code_latch u_lin (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_wipe    (i_soft_reset),
    .i_set     (i_lin_fault_set),
    .i_code    (i_lin_fault_code),
    .i_clr     (clr_bus),
    .o_code    (lin_code)
  );
  dbs_code_latch u_can (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_wipe    (i_soft_reset),
    .i_set     (i_can_fault_set),
    .i_code    (i_can_fault_code),
    .i_clr     (clr_bus),
    .o_code    (can_code)
  );

  // CAN timeout flag and its clear hold-off
  always @(posedge i_clk_sys) begin
    if (wipe) begin
      can_timeout_flag_q <= 1'b0;
      can_timeout_flag_arm_q        <= 1'b0;
      can_timeout_flag_hold_q       <= 1'b0;
    end else begin
      // Timeout sets on the rising edge of bus silence while selective
      // wake is enabled, and outlives the silence itself
      can_timeout_flag_arm_q <= i_can_bus_silence_flag;
      if (i_can_bus_silence_flag && !can_timeout_flag_arm_q && i_selective_wake_enable_bit) begin
        can_timeout_flag_q <= 1'b1;
        can_timeout_flag_hold_q       <= 1'b1;
      end else begin
        // Clear is held off until the interrupt pin falls, so a
        // timeout raised between two pulses is never lost
        if (interrupt_out_n_fall) begin
          can_timeout_flag_hold_q <= 1'b0;
        end
        if (clr_bus && !can_timeout_flag_hold_q) begin
          can_timeout_flag_q <= 1'b0;
        end
      end
    end
  end

  // Selective wake system error and CAN supply flags
  always @(posedge i_clk_sys) begin
    if (wipe) begin
      selective_wake_system_error_q  <= 1'b0;
      can_low_q <= 1'b0;
    end else begin
      // System error only counts while selective wake is on
      if (i_swk_sys_error && i_selective_wake_enable_bit) begin
        selective_wake_system_error_q <= 1'b1;
      end else if (clr_bus) begin
        selective_wake_system_error_q <= 1'b0;
      end
      // Comparator is live only in normal or receive-only mode
      if (i_can_supply_low && uv_det_en) begin
        can_low_q <= 1'b1;
      end else if (clr_bus) begin
        can_low_q <= 1'b0;
      end
    end
  end

  // Transmitter cut follows the live comparator, not the sticky flag,
  // so the transmitter comes back once the supply recovers
  always @(posedge i_clk_sys) begin
    if (wipe) begin
      o_can_tx_disable <= 1'b0;
    end else begin
      o_can_tx_disable <= i_can_supply_low & uv_det_en;
    end
  end

  // Next read word; zero whenever no mapped read is strobed
  reg [15:0] rd_data_d;
  always @* begin
    rd_data_d = `DBS_REG_RESET;
    if (rd_dev) begin
      rd_data_d = dev_image(i_crc_enabled, crc_err_q, prior_q, software_development_mode_flag_s,
                            wd_cnt_q, bad_cmd_q, fail_q);
    end else if (rd_bus) begin
      rd_data_d = bus_image(lin_code, can_timeout_flag_q, selective_wake_system_error_q,
                            can_code, can_low_q);
    end
  end

  // Read answer, registered one cycle after the strobe; the image is
  // taken before any clear of the same edge lands, so a set bit is seen
  always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= `DBS_REG_RESET;
    end else begin
      o_rd_valid <= rd_dev | rd_bus;
      o_rd_data  <= rd_data_d;
    end
  end

endmodule // dbs_status_regs

// [verification/dbs_host_model.sv]
// Host side model issuing status register reads
`timescale 1ns/1ps
module dbs_host_model (
  input  wire        i_clk_sys,
  input  wire        i_rd_valid,
  input  wire [15:0] i_rd_data,
  output reg         o_rd_stb = 1'b0,
  output reg  [6:0]  o_rd_addr = 7'h00,
  output reg         o_rd_clear = 1'b0,
  output reg  [15:0] o_q = 16'h0000,
  output reg         o_got = 1'b0
);
  // Strobe for one edge, idle lines inverted, answer taken one edge later
  task rd(input logic [6:0] a, input logic c);
    @(posedge i_clk_sys);
    o_rd_stb <= 1'b1;
    o_rd_addr <= a;
    o_rd_clear <= c;
    @(posedge i_clk_sys);
    o_rd_stb <= 1'b0;
    o_rd_addr <= ~a;
    o_rd_clear <= ~c;
    @(posedge i_clk_sys);
    o_got = i_rd_valid;
    o_q = i_rd_data;
  endtask
endmodule // dbs_host_model

// [verification/dbs_status_regs_checker.sv]
// Port level checks of the status registers
`timescale 1ns/1ps
module dbs_status_checker (
  input wire        i_clk_sys,
  input wire        i_nrst,
  input wire        i_rd_stb,
  input wire [6:0]  i_rd_addr,
  input wire        i_crc_enabled,
  input wire        i_software_development_mode_flag_pin,
  input wire        i_can_supply_low,
  input wire        i_can_normal_mode,
  input wire        i_can_rx_only_mode,
  input wire        o_rd_valid,
  input wire [15:0] o_rd_data,
  input wire        o_can_tx_disable
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // Mapped read request
  wire hit = i_rd_stb && (i_rd_addr == 7'h42 || i_rd_addr == 7'h43);
  // Answers of each register
  sequence s_dev;
    o_rd_valid && $past(i_rd_addr) == 7'h42;
  endsequence
  sequence s_bus;
    o_rd_valid && $past(i_rd_addr) == 7'h43;
  endsequence
  AST_ANSWER: assert property (hit |=> o_rd_valid)
    else $error("read not answered");
  AST_CAUSE: assert property (o_rd_valid |-> $past(hit))
    else $error("answer without read");
  AST_IDLE: assert property (!o_rd_valid |-> o_rd_data == 16'h0000)
    else $error("data outside answer");
  AST_DEV_RSVD: assert property (s_dev |-> o_rd_data[15:10] == 6'h00 && !o_rd_data[5])
    else $error("device reserved bits set");
  AST_PRIOR: assert property (s_dev |-> o_rd_data[7:6] != 2'h3)
    else $error("prior state reserved code");
  AST_BUS_RSVD: assert property (s_bus |-> o_rd_data[15:7] == 9'h000)
    else $error("bus reserved bits set");
  AST_CRC_STAT: assert property ($stable(i_crc_enabled) ##1 s_dev |->
    o_rd_data[9] == $past(i_crc_enabled)) else $error("check state bit wrong");
  AST_SWDEV: assert property ($stable(i_software_development_mode_flag_pin) [*4] ##1 s_dev |->
    o_rd_data[4] == $past(i_software_development_mode_flag_pin)) else $error("dev mode bit wrong");
  AST_TX_DIS: assert property ((i_can_supply_low &&
    (i_can_normal_mode || i_can_rx_only_mode)) [*3] |-> o_can_tx_disable)
    else $error("transmitter not disabled");
endmodule // dbs_status_checker
bind dbs_status_regs dbs_status_checker u_chk (.i_clk_sys, .i_nrst, .i_rd_stb, .i_rd_addr,
  .i_crc_enabled, .i_software_development_mode_flag_pin, .i_can_supply_low, .i_can_normal_mode,
  .i_can_rx_only_mode, .o_rd_valid, .o_rd_data, .o_can_tx_disable);

// [verification/dbs_status_regs_tb.sv]
// Self-checking bench of the status registers
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module dbs_status_regs_tb;
  typedef struct packed {logic [18:0] e; logic [1:0] c; logic b; logic [15:0] x;} dbs_row_t;
  logic        i_clk_sys = 1'b0;
  logic        i_nrst = 1'b0;
  logic        rst_s = 1'b0;
  logic        restart = 1'b0;
  logic        crc_en = 1'b0;
  logic        pin = 1'b0;
  logic        int_n = 1'b1;
  logic [18:0] ev = 19'h00000;
  logic [1:0]  cd = 2'h0;
  logic [6:0]  addr;
  logic [15:0] dat;
  logic        stb, clr, vld, txd;
  int          n_mismatch = 0;
  int          total_checks = 0;
  // Event bits, code, bus register select, expected answer
  dbs_row_t rows [24] = '{
    '{19'h00001, 2'h0, 1'b0, 16'h0300}, '{19'h00003, 2'h0, 1'b0, 16'h0200},
    '{19'h00004, 2'h0, 1'b0, 16'h0202}, '{19'h00008, 2'h0, 1'b0, 16'h0201},
    '{19'h00020, 2'h0, 1'b0, 16'h0240}, '{19'h00040, 2'h0, 1'b0, 16'h0240},
    '{19'h00080, 2'h0, 1'b0, 16'h0240}, '{19'h00100, 2'h0, 1'b0, 16'h0240},
    '{19'h00200, 2'h0, 1'b0, 16'h0280}, '{19'h00400, 2'h1, 1'b1, 16'h0020},
    '{19'h00400, 2'h2, 1'b1, 16'h0040}, '{19'h00400, 2'h3, 1'b1, 16'h0060},
    '{19'h00800, 2'h1, 1'b1, 16'h0002}, '{19'h00800, 2'h2, 1'b1, 16'h0004},
    '{19'h00800, 2'h3, 1'b1, 16'h0006}, '{19'h03000, 2'h0, 1'b1, 16'h0008},
    '{19'h02000, 2'h0, 1'b1, 16'h0000}, '{19'h20000, 2'h0, 1'b1, 16'h0000},
    '{19'h00010, 2'h0, 1'b0, 16'h0244}, '{19'h00010, 2'h0, 1'b0, 16'h0248},
    '{19'h00010, 2'h0, 1'b0, 16'h024C}, '{19'h00010, 2'h0, 1'b0, 16'h024C},
    '{19'h40000, 2'h0, 1'b0, 16'h0200}, '{19'h00000, 2'h0, 1'b1, 16'h0000}};
  dbs_host_model host (.i_clk_sys(i_clk_sys), .i_rd_valid(vld), .i_rd_data(dat),
    .o_rd_stb(stb), .o_rd_addr(addr), .o_rd_clear(clr), .o_q(), .o_got());
  dbs_status_regs dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_soft_reset(rst_s),
    .i_restart(restart), .i_rd_stb(stb), .i_rd_addr(addr), .i_rd_clear(clr),
    .i_crc_seq(ev[1]), .i_crc_bad(ev[0]), .i_cmd_invalid(ev[2]), .i_crc_enabled(crc_en),
    .i_watchdog_fault_count(ev[4]), .i_wd_clear(ev[18]), .i_severe_overtemp_shutdown(ev[5]),
    .i_main_regulator_undervoltage(ev[6]), .i_sleep_no_wake_src(ev[7]),
    .i_failsafe_wake(ev[8]), .i_sleep_entry(ev[9]), .i_failure(ev[3]), .i_software_development_mode_flag_pin(pin),
    .i_lin_fault_set(ev[10]), .i_lin_fault_code(cd), .i_can_fault_set(ev[11]),
    .i_can_fault_code(cd), .i_can_bus_silence_flag(ev[17]),
    .i_selective_wake_enable_bit(ev[12]), .i_swk_sys_error(ev[13]),
    .i_can_supply_low(ev[14]), .i_can_normal_mode(ev[15]), .i_can_rx_only_mode(ev[16]),
    .i_interrupt_out_n(int_n), .o_rd_valid(vld), .o_rd_data(dat), .o_can_tx_disable(txd));
  // Clock
  always #5 i_clk_sys = ~i_clk_sys;
  // One cycle event pulse, then settle
  task p(input logic [18:0] e, input logic [1:0] c);
    @(posedge i_clk_sys);
    ev <= e;
    cd <= c;
    @(posedge i_clk_sys);
    ev <= '0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  // Read one register and compare what the host took, with no port hop
  task t(input logic b, input logic c, input logic [15:0] x);
    host.rd({6'h21, b}, c);
    `CHK(host.o_got, 1'b1)
    `CHK(host.o_q, x)
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    complete_run;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    t(0, 1, 16'h0000);
    t(1, 1, 16'h0000);
    crc_en <= 1'b1;
    foreach (rows[i]) begin
      p(rows[i].e, rows[i].c);
      t(rows[i].b, 1, rows[i].x);
    end
    p(19'h0000C, 2'h0);
    t(0, 0, 16'h0203);
    t(0, 1, 16'h0203);
    t(0, 1, 16'h0200);
    p(19'h0040C, 2'h1);
    restart <= 1'b1;
    t(0, 0, 16'h0203);
    t(1, 0, 16'h0020);
    restart <= 1'b0;
    rst_s <= 1'b1;
    @(posedge i_clk_sys);
    rst_s <= 1'b0;
    t(0, 1, 16'h0200);
    t(1, 1, 16'h0000);
    p(19'h21000, 2'h0);
    t(1, 1, 16'h0010);
    t(1, 1, 16'h0010);
    int_n <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    int_n <= 1'b1;
    t(1, 1, 16'h0010);
    t(1, 1, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      ev <= (k == 2) ? 19'h04000 : (k == 1 ? 19'h14000 : 19'h0C000);
      repeat (4) @(posedge i_clk_sys);
      `CHK(txd, k != 2)
      ev <= '0;
      t(1, 1, {15'h0000, k != 2});
      `CHK(txd, 1'b0)
    end
    pin <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    t(0, 1, 16'h0210);
    t(0, 1, 16'h0210);
    pin <= 1'b0;
    host.rd(7'h44, 1'b1);
    `CHK(host.o_got, 1'b0)
    complete_run;
  end
endmodule // dbs_status_regs_tb
